// file: seg_xlat_pkg.sv
// Purpose: shared constants, field layouts and carrier types for segment translation
// Assumes: one processor clock, descriptor memory answers on the same clock
// Notes: descriptor layout is the classic eight-byte code/data descriptor
package seg_xlat_pkg;

	// =====================================================================
	// segment registers and selector fields
	// =====================================================================
	localparam int SEG_COUNT = 6;
	typedef enum logic [2:0] {
		SEG_CODE = 3'h0,
		SEG_STACK = 3'h1,
		SEG_DATA = 3'h2,
		SEG_EXTRA1 = 3'h3,
		SEG_EXTRA2 = 3'h4,
		SEG_EXTRA3 = 3'h5
	} seg_id_t;

	localparam int SEL_INDEX_LSB = 3;
	localparam int SEL_INDEX_MSB = 15;
	localparam int SEL_TABLE_BIT = 2;
	localparam int SEL_PRIV_MSB = 1;
	localparam int SEL_PRIV_LSB = 0;
	localparam int DESC_SIZE_SHIFT = 3;
	localparam logic [15:0] SEL_RESET = 16'h0000;

	// =====================================================================
	// descriptor field positions
	// =====================================================================
	localparam int DESC_LIMIT_LO_MSB = 15;
	localparam int DESC_BASE_LO_LSB = 16;
	localparam int DESC_BASE_LO_MSB = 39;
	localparam int DESC_TYPE_LSB = 40;
	localparam int DESC_TYPE_MSB = 43;
	localparam int DESC_APP_BIT = 44;
	localparam int DESC_DPL_LSB = 45;
	localparam int DESC_DPL_MSB = 46;
	localparam int DESC_PRESENT_BIT = 47;
	localparam int DESC_LIMIT_HI_LSB = 48;
	localparam int DESC_LIMIT_HI_MSB = 51;
	localparam int DESC_LONG_BIT = 53;
	localparam int DESC_BIG_BIT = 54;
	localparam int DESC_GRAN_BIT = 55;
	localparam int DESC_BASE_HI_LSB = 56;
	localparam int DESC_BASE_HI_MSB = 63;
	localparam int TYPE_CODE_BIT = 3;
	localparam int TYPE_DOWN_BIT = 2;
	localparam int TYPE_RW_BIT = 1;
	localparam logic [11:0] GRAN_FILL = 12'hFFF;
	localparam logic [31:0] DOWN_TOP_BIG = 32'hFFFFFFFF;
	localparam logic [31:0] DOWN_TOP_SMALL = 32'h0000FFFF;

	// =====================================================================
	// physical width selection
	// =====================================================================
	localparam int CR4_EXT_PHYS_BIT = 5;
	localparam int PHYS_BITS_LEGACY = 32;
	localparam int PHYS_BITS_EXT = 36;
	localparam int ID_WIDTH_MSB = 7;

	// =====================================================================
	// carriers and state
	// =====================================================================
	typedef struct packed {
		logic [15:0] selector;
		logic [31:0] base;
		logic [31:0] limit;
		logic usable;
		logic present;
		logic code;
		logic expand_down;
		logic rw;
		logic big;
		logic long_code;
		logic [1:0] descriptor_privilege_level;
	} seg_cache_t;

	localparam seg_cache_t CACHE_RESET = '0;

	typedef struct packed {
		seg_id_t seg;
		logic [15:0] selector;
		logic implied_load;
	} seg_load_t;

	typedef struct packed {
		seg_id_t seg;
		logic [63:0] offset;
		logic write;
		logic fetch;
	} mem_access_t;

	typedef enum logic [1:0] {
		FLT_NONE = 2'h0,
		FLT_GENERAL = 2'h1,
		FLT_NOT_PRESENT = 2'h2,
		FLT_STACK = 2'h3
	} fault_t;

	typedef enum logic [1:0] {
		LD_IDLE = 2'h0,
		LD_FETCH = 2'h1,
		LD_WAIT = 2'h3
	} load_state_t;

endpackage

// file: segment_address_translation.sv
// Purpose: logical to linear to physical address translation through six segment registers
// Assumes: descriptor memory and instruction execution share sys_clk; one load at a time
// Notes: paging itself lives elsewhere; this block hands linear addresses to it
//
// What this block does
// - legacy protected mode: flat 32-bit physical space
// - control register four bit 5 widens to 36
// - report physical width in bits 7-0
// - logical address is selector plus offset
// - every logical address yields a linear address
// - fetch descriptor only when selector loads
// - outside 64-bit sub-mode: check rights and limit before forming address
// - linear address is cached base plus offset
// - no paging: linear goes out as physical, masked to the physical width (cuts bits only in 64-bit sub-mode)
// - 64-bit sub-mode: wide sums, canonical check
// - code descriptor long flag picks 64-bit code
// - index bits 15-3, table base plus index*8
// - selector bit 2 picks global or local
// - selector bits 1-0 are requested privilege
// - null selector into data registers: no fault
// - access through null selector faults; in 64-bit sub-mode only through code
// - null into code or stack: general fault
// - six registers: code, stack, four data
// - load fills hidden base, limit, access cache
// - explicit and implied loads both accepted
// - visible selector readable into general register
// - 64-bit: first four bases read as zero
// - 64-bit: no runtime limit checks
// - expand-up overrun: general or stack fault
module segment_address_translation
	import seg_xlat_pkg::*;
#(
	parameter int PHYS_ADDR_BITS = 40,
	parameter int LIN_ADDR_BITS = 48
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [31:0] control_register_four,
	input wire logic paging_enable,
	input wire logic wide_address_operation,
	input wire logic [63:0] global_table_base_reg,
	input wire logic [63:0] local_table_base_reg,
	input wire logic load_valid,
	input wire seg_load_t load_req,
	output logic load_ready,
	output logic load_done,
	output fault_t load_fault,
	output logic desc_req_valid,
	output logic [63:0] desc_req_addr,
	input wire logic desc_rsp_valid,
	input wire logic [63:0] desc_rsp_data,
	input wire logic acc_valid,
	input wire mem_access_t acc_req,
	output logic acc_done,
	output fault_t acc_fault,
	output logic [63:0] linear_addr,
	output logic phys_valid,
	output logic [63:0] phys_addr,
	output logic paging_req_valid,
	output logic code_is_64bit,
	input wire seg_id_t store_seg,
	output logic [15:0] store_selector,
	output logic [31:0] phys_width_word
);

	// =====================================================================
	// decode helpers
	// =====================================================================

	// index zero in the global table is the null selector, whatever the privilege bits
	function automatic logic sel_is_null(input logic [15:0] sel);
		return (sel[SEL_INDEX_MSB:SEL_INDEX_LSB] == 13'h0000) && !sel[SEL_TABLE_BIT];
	endfunction

	// unpack an eight-byte descriptor into the hidden cache format
	function automatic seg_cache_t desc_unpack(input logic [63:0] d, input logic [15:0] sel);
		seg_cache_t c;
		logic [19:0] raw_limit;
		logic [3:0] typ;
		c = CACHE_RESET;
		typ = d[DESC_TYPE_MSB:DESC_TYPE_LSB];
		raw_limit = {d[DESC_LIMIT_HI_MSB:DESC_LIMIT_HI_LSB], d[DESC_LIMIT_LO_MSB:0]};
		c.selector = sel;
		c.base = {d[DESC_BASE_HI_MSB:DESC_BASE_HI_LSB], d[DESC_BASE_LO_MSB:DESC_BASE_LO_LSB]};
		c.limit = d[DESC_GRAN_BIT] ? {raw_limit, GRAN_FILL} : {12'h000, raw_limit};
		c.usable = 1'b1;
		c.present = d[DESC_PRESENT_BIT];
		c.code = typ[TYPE_CODE_BIT];
		c.expand_down = !typ[TYPE_CODE_BIT] && typ[TYPE_DOWN_BIT];
		c.rw = typ[TYPE_RW_BIT];
		c.big = d[DESC_BIG_BIT];
		c.long_code = typ[TYPE_CODE_BIT] && d[DESC_LONG_BIT];
		c.descriptor_privilege_level = d[DESC_DPL_MSB:DESC_DPL_LSB];
		return c;
	endfunction

	// canonical means every bit above the implemented top copies it
	function automatic logic is_canonical(input logic [63:0] a);
		logic ok;
		ok = 1'b1;
		for (int i = LIN_ADDR_BITS; i < 64; i++) begin
			if (a[i] != a[LIN_ADDR_BITS - 1]) begin
				ok = 1'b0;
			end
		end
		return ok;
	endfunction

	// =====================================================================
	// segment register file: visible selector plus hidden cache
	// =====================================================================
	seg_cache_t sreg_reg [SEG_COUNT];
	load_state_t ld_state_reg;
	seg_load_t ld_reg;
	logic commit_pulse;
	seg_cache_t commit_value;

	// =====================================================================
	// load sequencer
	// =====================================================================
	logic ld_take;
	logic ld_null;
	logic ld_null_bad;
	logic [63:0] table_base;
	logic [63:0] desc_offset;
	seg_cache_t rsp_cache;
	logic rsp_bad_type;

	assign ld_take = load_valid && load_ready;
	assign ld_null = sel_is_null(load_req.selector);
	assign ld_null_bad = ld_null && (load_req.seg == SEG_CODE || load_req.seg == SEG_STACK);
	assign table_base = load_req.selector[SEL_TABLE_BIT] ? local_table_base_reg
		: global_table_base_reg;
	assign desc_offset = {48'h0000_0000_0000, load_req.selector[SEL_INDEX_MSB:SEL_INDEX_LSB],
		3'h0};
	assign rsp_cache = desc_unpack(desc_rsp_data, ld_reg.selector);
	// stack wants writable data, code register wants code, others reject system entries
	assign rsp_bad_type = !desc_rsp_data[DESC_APP_BIT]
		|| (ld_reg.seg == SEG_CODE && !rsp_cache.code)
		|| (ld_reg.seg == SEG_STACK && (rsp_cache.code || !rsp_cache.rw));

	// state of the descriptor fetch; explicit and implied loads share one path
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ld_state_reg <= LD_IDLE;
		end else begin
			unique case (ld_state_reg)
				LD_IDLE: begin
					if (ld_take && !ld_null) begin
						ld_state_reg <= LD_FETCH;
					end
				end
				LD_FETCH: begin
					ld_state_reg <= LD_WAIT;
				end
				LD_WAIT: begin
					if (desc_rsp_valid) begin
						ld_state_reg <= LD_IDLE;
					end
				end
			endcase
		end
	end

	// capture the load request while the fetch is in flight
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ld_reg <= '0;
		end else if (ld_take) begin
			ld_reg <= load_req;
		end
	end

	// descriptor read request toward the table memory
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			desc_req_valid <= 1'b0;
			desc_req_addr <= 64'h0000_0000_0000_0000;
		end else begin
			desc_req_valid <= ld_take && !ld_null;
			if (ld_take && !ld_null) begin
				desc_req_addr <= table_base + desc_offset;
			end
		end
	end

	// ready drops for the whole fetch so a second load cannot overtake
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			load_ready <= 1'b1;
		end else if (ld_take && !ld_null) begin
			load_ready <= 1'b0;
		end else if (ld_state_reg == LD_WAIT && desc_rsp_valid) begin
			load_ready <= 1'b1;
		end
	end

	// decide what is written back and report completion
	always_comb begin
		commit_pulse = 1'b0;
		commit_value = CACHE_RESET;
		if (ld_take && ld_null && !ld_null_bad) begin
			commit_pulse = 1'b1;
			commit_value.selector = load_req.selector;
		end else if (ld_state_reg == LD_WAIT && desc_rsp_valid && !rsp_bad_type
			&& rsp_cache.present) begin
			commit_pulse = 1'b1;
			commit_value = rsp_cache;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			load_done <= 1'b0;
			load_fault <= FLT_NONE;
		end else begin
			load_done <= (ld_take && ld_null) || (ld_state_reg == LD_WAIT && desc_rsp_valid);
			if (ld_take && ld_null_bad) begin
				load_fault <= FLT_GENERAL;
			end else if (ld_take && ld_null) begin
				load_fault <= FLT_NONE;
			end else if (ld_state_reg == LD_WAIT && desc_rsp_valid) begin
				if (rsp_bad_type) begin
					load_fault <= FLT_GENERAL;
				end else if (!rsp_cache.present) begin
					load_fault <= (ld_reg.seg == SEG_STACK) ? FLT_STACK : FLT_NOT_PRESENT;
				end else begin
					load_fault <= FLT_NONE;
				end
			end
		end
	end

	// one write updates selector and cache as a unit; a faulting load changes nothing
	genvar g;
	generate
		for (g = 0; g < SEG_COUNT; g++) begin : g_sreg
			always_ff @(posedge sys_clk or negedge rstn) begin
				if (!rstn) begin
					sreg_reg[g] <= CACHE_RESET;
				end else if (commit_pulse
					&& ((ld_take && ld_null) ? load_req.seg : ld_reg.seg) == seg_id_t'(g)) begin
					sreg_reg[g] <= commit_value;
				end
			end
		end
	endgenerate

	// =====================================================================
	// selector store and identification
	// =====================================================================

	// visible part copied out for a move into a general register
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			store_selector <= SEL_RESET;
		end else begin
			store_selector <= sreg_reg[store_seg].selector;
		end
	end

	// identification word: implemented physical width in the low byte
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			phys_width_word <= 32'h0000_0000;
		end else begin
			phys_width_word <= {24'h000000, PHYS_ADDR_BITS[ID_WIDTH_MSB:0]};
		end
	end

	// =====================================================================
	// access path: checks, sum and physical hand-off
	// =====================================================================
	seg_cache_t cur;
	logic mode64;
	logic [63:0] base_eff;
	logic [31:0] lin32;
	logic [63:0] lin_next;
	logic [31:0] off32;
	logic [31:0] down_top;
	logic limit_bad;
	logic rights_bad;
	fault_t fault_next;
	logic [63:0] phys_mask;

	assign cur = sreg_reg[acc_req.seg];
	assign mode64 = wide_address_operation && sreg_reg[SEG_CODE].long_code;
	assign off32 = acc_req.offset[31:0];
	assign down_top = cur.big ? DOWN_TOP_BIG : DOWN_TOP_SMALL;

	// offset check against the cached limit in either direction
	always_comb begin
		if (mode64) begin
			limit_bad = 1'b0;
		end else if (cur.expand_down) begin
			limit_bad = (off32 <= cur.limit) || (off32 > down_top);
		end else begin
			limit_bad = off32 > cur.limit;
		end
	end

	// rights: fetch only from code, no writes to code or read-only data
	always_comb begin
		if (acc_req.fetch) begin
			rights_bad = !cur.code;
		end else if (acc_req.write) begin
			rights_bad = cur.code || !cur.rw;
		end else begin
			rights_bad = cur.code && !cur.rw;
		end
		if (mode64 && (acc_req.seg == SEG_EXTRA2 || acc_req.seg == SEG_EXTRA3)) begin
			rights_bad = 1'b0;
		end
	end

	// linear sum from the cached base, never from memory
	always_comb begin
		if (mode64 && acc_req.seg != SEG_EXTRA2 && acc_req.seg != SEG_EXTRA3) begin
			base_eff = 64'h0000_0000_0000_0000;
		end else begin
			base_eff = {32'h0000_0000, cur.base};
		end
		lin32 = cur.base + off32;
		lin_next = mode64 ? (base_eff + acc_req.offset) : {32'h0000_0000, lin32};
	end

	// fault priority: null selector, then rights, then range, then canonical form
	always_comb begin
		fault_next = FLT_NONE;
		if (!cur.usable && !mode64) begin
			fault_next = FLT_GENERAL;
		end else if (!cur.usable && mode64 && acc_req.seg == SEG_CODE) begin
			fault_next = FLT_GENERAL;
		end else if (rights_bad && !mode64) begin
			fault_next = FLT_GENERAL;
		end else if (limit_bad) begin
			fault_next = (acc_req.seg == SEG_STACK) ? FLT_STACK : FLT_GENERAL;
		end else if (mode64 && !is_canonical(lin_next)) begin
			fault_next = (acc_req.seg == SEG_STACK) ? FLT_STACK : FLT_GENERAL;
		end
	end

	// physical width: 32 legacy, 36 extended, implementation width in 64-bit mode
	always_comb begin
		phys_mask = 64'h0000_0000_FFFF_FFFF;
		if (mode64) begin
			phys_mask = (64'h1 << PHYS_ADDR_BITS) - 64'h1;
		end else if (control_register_four[CR4_EXT_PHYS_BIT]) begin
			phys_mask = (64'h1 << PHYS_BITS_EXT) - 64'h1;
		end
	end

	// registered answer one edge after the request
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			acc_done <= 1'b0;
			acc_fault <= FLT_NONE;
			linear_addr <= 64'h0000_0000_0000_0000;
			phys_valid <= 1'b0;
			phys_addr <= 64'h0000_0000_0000_0000;
			paging_req_valid <= 1'b0;
		end else begin
			acc_done <= acc_valid;
			phys_valid <= acc_valid && fault_next == FLT_NONE && !paging_enable;
			paging_req_valid <= acc_valid && fault_next == FLT_NONE && paging_enable;
			if (acc_valid) begin
				acc_fault <= fault_next;
				linear_addr <= lin_next;
				phys_addr <= lin_next & phys_mask;
			end
		end
	end

	// reports whether the loaded code segment runs 64-bit code
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			code_is_64bit <= 1'b0;
		end else begin
			code_is_64bit <= mode64;
		end
	end

endmodule

// file: segment_address_translation_sva.sv
// Purpose: port-level property checks for segment address translation
// Assumes: one clock, reset low and asynchronous
// Notes: attached by bind from the bench top file
module segment_address_translation_sva
	import seg_xlat_pkg::*;
#(
	parameter int PHYS_ADDR_BITS = 40,
	parameter int LIN_ADDR_BITS = 48
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic paging_enable,
	input wire logic [63:0] global_table_base_reg,
	input wire logic [63:0] local_table_base_reg,
	input wire logic load_valid,
	input wire seg_load_t load_req,
	input wire logic load_ready,
	input wire logic load_done,
	input wire fault_t load_fault,
	input wire logic desc_req_valid,
	input wire logic [63:0] desc_req_addr,
	input wire logic desc_rsp_valid,
	input wire logic acc_valid,
	input wire logic acc_done,
	input wire fault_t acc_fault,
	input wire logic [63:0] linear_addr,
	input wire logic phys_valid,
	input wire logic [63:0] phys_addr,
	input wire logic paging_req_valid,
	input wire logic [31:0] phys_width_word
);
	timeunit 1ns;
	timeprecision 1ns;
	// =====================================
	// helpers
	// =====================================
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	logic take;
	logic null_sel;
	logic cs_ss;
	logic [63:0] want_addr;
	// load taken, null selector and expected descriptor address
	assign take = load_valid && load_ready;
	assign null_sel = load_req.selector[15:2] == 14'h0000;
	assign cs_ss = load_req.seg == SEG_CODE || load_req.seg == SEG_STACK;
	assign want_addr = (load_req.selector[2] ? local_table_base_reg : global_table_base_reg)
		+ 64'({load_req.selector[15:3], 3'h0});

	// =====================================
	// assertions
	// =====================================
	a_acc_answer: assert property (acc_valid |=> acc_done)
		else $error("access not answered next cycle");
	a_fault_blocks: assert property (acc_done && acc_fault != FLT_NONE
		|-> !phys_valid && !paging_req_valid)
		else $error("faulted access still issued");
	a_phys_route: assert property (phys_valid |-> !$past(paging_enable)
		&& phys_addr[31:0] == linear_addr[31:0])
		else $error("physical address not the linear one");
	a_paging_route: assert property (paging_req_valid |-> $past(paging_enable) && !phys_valid)
		else $error("paging request while paging off");
	a_desc_cause: assert property (desc_req_valid |-> $past(take))
		else $error("descriptor fetch without a load");
	a_desc_addr: assert property (take && !null_sel |=> desc_req_valid
		&& desc_req_addr == $past(want_addr))
		else $error("descriptor address wrong");
	a_null_quick: assert property (take && null_sel |=> load_done && !desc_req_valid)
		else $error("null load fetched or stalled");
	a_null_cs_ss: assert property (take && null_sel && cs_ss |=> load_fault == FLT_GENERAL)
		else $error("null code or stack load not faulted");
	a_null_ds_ok: assert property (take && null_sel && !cs_ss |=> load_fault == FLT_NONE)
		else $error("null data load faulted");
	a_rsp_load: assert property (desc_rsp_valid && !load_ready && !desc_req_valid
		|=> load_done && load_ready)
		else $error("descriptor answer not completing load");
	a_fault_hold: assert property ($changed(acc_fault) |-> acc_done)
		else $error("access fault changed without access");
	a_width_id: assert property ($past(rstn) |-> phys_width_word == 32'(PHYS_ADDR_BITS))
		else $error("physical width word wrong");

	// main scenarios reached
	c_fetch: cover property (take && !null_sel);
	c_stack: cover property (acc_done && acc_fault == FLT_STACK);
	c_paging: cover property (paging_req_valid);
endmodule

// file: desc_mem.sv
// Purpose: descriptor table memory seen from the translation block
// Assumes: one word per fetch, answered after lat edges
// Notes: outside an answer the data lines carry junk that toggles
module desc_mem (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic desc_req_valid,
	input wire logic [63:0] desc_req_addr,
	output logic desc_rsp_valid,
	output logic [63:0] desc_rsp_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [63:0] mem [logic [63:0]];
	logic [63:0] addr_hold;
	int lat = 2;
	int cnt = 0;

	// latch the fetch address, answer after lat edges
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cnt = 0;
			desc_rsp_valid <= 1'h0;
			desc_rsp_data <= 64'hFFFFFFFFFFFFFFFF;
		end else begin
			desc_rsp_valid <= cnt == 1;
			if (cnt == 1) desc_rsp_data <= mem[addr_hold];
			else desc_rsp_data <= ~desc_rsp_data;
			if (desc_req_valid) begin
				cnt = lat;
				addr_hold = desc_req_addr;
			end else if (cnt > 0) cnt--;
		end
	end
endmodule

// file: tb.sv
// Purpose: self-checking bench for segment address translation
// Assumes: descriptor model answers each fetch after a set delay
// Notes: loads and accesses run from tables; odd cases follow by hand
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import seg_xlat_pkg::*;
	typedef struct {seg_id_t s; logic [15:0] sel; fault_t f; logic [63:0] a;} ld_row_t;
	typedef struct {seg_id_t s; logic [63:0] o; logic w; fault_t f; logic [63:0] l;} ac_row_t;
	logic sys_clk = 1'h0;
	logic rstn = 1'h0;
	logic [31:0] control_register_four = 32'h0;
	logic paging_enable = 1'h0;
	logic wide_address_operation = 1'h0;
	logic [63:0] global_table_base_reg = 64'h1000;
	logic [63:0] local_table_base_reg = 64'h8000;
	logic load_valid = 1'h0;
	seg_load_t load_req = '0;
	logic acc_valid = 1'h0;
	mem_access_t acc_req = '0;
	seg_id_t store_seg = SEG_CODE;
	logic load_ready, load_done, desc_req_valid, desc_rsp_valid, acc_done;
	logic phys_valid, paging_req_valid, code_is_64bit;
	fault_t load_fault, acc_fault;
	logic [63:0] desc_req_addr, desc_rsp_data, linear_addr, phys_addr;
	logic [15:0] store_selector;
	logic [31:0] phys_width_word;
	int n_fail = 0;
	int n_tests = 0;
	ld_row_t lds[9] = '{'{SEG_CODE, 16'h0008, FLT_NONE, 64'h1008},
		'{SEG_DATA, 16'h0010, FLT_NONE, 64'h1010}, '{SEG_STACK, 16'h0023, FLT_NONE, 64'h1020},
		'{SEG_EXTRA1, 16'h000C, FLT_NONE, 64'h8008}, '{SEG_EXTRA3, 16'h0003, FLT_NONE, 64'h0},
		'{SEG_CODE, 16'h0000, FLT_GENERAL, 64'h0}, '{SEG_STACK, 16'h0008, FLT_GENERAL, 64'h1008},
		'{SEG_DATA, 16'h0030, FLT_NOT_PRESENT, 64'h1030}, '{SEG_STACK, 16'h0030, FLT_STACK, 64'h1030}};
	ac_row_t acs[10] = '{'{SEG_DATA, 64'h0, 1'h0, FLT_NONE, 64'h100000},
		'{SEG_DATA, 64'hFFF, 1'h1, FLT_NONE, 64'h100FFF}, '{SEG_DATA, 64'h1000, 1'h0, FLT_GENERAL, 64'h0},
		'{SEG_STACK, 64'h1000, 1'h1, FLT_STACK, 64'h0}, '{SEG_STACK, 64'hFFC, 1'h1, FLT_NONE, 64'h200FFC},
		'{SEG_CODE, 64'h10, 1'h1, FLT_GENERAL, 64'h0}, '{SEG_CODE, 64'h10, 1'h0, FLT_NONE, 64'h10},
		'{SEG_EXTRA1, 64'h20, 1'h0, FLT_NONE, 64'h10}, '{SEG_EXTRA2, 64'h0, 1'h0, FLT_GENERAL, 64'h0},
		'{SEG_EXTRA3, 64'h0, 1'h0, FLT_GENERAL, 64'h0}};
	logic [15:0] keep[6] = '{16'h0008, 16'h0023, 16'h0010, 16'h000C, 16'h0000, 16'h0003};

	// =====================================
	// clock, design and descriptor memory
	// =====================================
	always #10 sys_clk = ~sys_clk;
	segment_address_translation uut (.sys_clk, .rstn, .control_register_four, .paging_enable,
		.wide_address_operation, .global_table_base_reg, .local_table_base_reg, .load_valid,
		.load_req, .load_ready, .load_done, .load_fault, .desc_req_valid, .desc_req_addr,
		.desc_rsp_valid, .desc_rsp_data, .acc_valid, .acc_req, .acc_done, .acc_fault,
		.linear_addr, .phys_valid, .phys_addr, .paging_req_valid, .code_is_64bit, .store_seg,
		.store_selector, .phys_width_word);
	desc_mem pm (.sys_clk, .rstn, .desc_req_valid, .desc_req_addr, .desc_rsp_valid, .desc_rsp_data);

	// =====================================
	// helpers
	// =====================================
	// build a code or data descriptor word
	function automatic logic [63:0] mk(logic [31:0] b, logic [3:0] t, logic p, logic lg);
		return {b[31:24], 1'h0, 1'h1, lg, 1'h0, 4'h0, p, 2'h0, 1'h1, t, b[23:0], 16'h0FFF};
	endfunction
	task automatic chk(logic [63:0] got, logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chkf(fault_t got, fault_t exp);
		chk(64'(got), 64'(exp));
	endtask
	// one segment load, held until taken, then wait for completion
	task automatic do_load(seg_id_t s, logic [15:0] sel, fault_t f, logic [63:0] a);
		int k;
		k = 0;
		@(posedge sys_clk);
		load_valid <= 1'h1;
		load_req <= '{s, sel, 1'h0};
		do @(posedge sys_clk); while (load_ready !== 1'h1);
		load_valid <= 1'h0;
		while (load_done !== 1'h1 && k < 60) begin
			@(posedge sys_clk);
			k++;
		end
		chk(load_done, 64'h1);
		chkf(load_fault, f);
		if (a != 64'h0) chk(desc_req_addr, a);
	endtask
	// one access, answered one cycle after the take
	task automatic do_acc(seg_id_t s, logic [63:0] o, logic w, fault_t f, logic [63:0] l,
		logic fe = 1'h0);
		@(posedge sys_clk);
		acc_valid <= 1'h1;
		acc_req <= '{s, o, w, fe};
		@(posedge sys_clk);
		acc_valid <= 1'h0;
		@(posedge sys_clk);
		chk(acc_done, 64'h1);
		chkf(acc_fault, f);
		chk(phys_valid, 64'(f == FLT_NONE && !paging_enable));
		chk(paging_req_valid, 64'(f == FLT_NONE && paging_enable));
		if (f == FLT_NONE) begin
			chk(linear_addr, l);
			chk(phys_addr, l);
		end
	endtask
	task automatic give_verdict();
		if (n_fail == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// =====================================
	// main sequence
	// =====================================
	initial begin
		pm.mem[64'h1008] = mk(32'h0, 4'hA, 1'h1, 1'h0);
		pm.mem[64'h1010] = mk(32'h100000, 4'h2, 1'h1, 1'h0);
		pm.mem[64'h1020] = mk(32'h200000, 4'h2, 1'h1, 1'h0);
		pm.mem[64'h8008] = mk(32'hFFFFFFF0, 4'h2, 1'h1, 1'h0);
		pm.mem[64'h1030] = mk(32'h0, 4'h2, 1'h0, 1'h0);
		pm.mem[64'h1018] = mk(32'h0, 4'hA, 1'h1, 1'h1);
		pm.mem[64'h1028] = mk(32'h3000, 4'h2, 1'h1, 1'h0);
		pm.mem[64'h1038] = mk(32'h4000, 4'h6, 1'h1, 1'h0);
		pm.mem[64'h1040] = mk(32'h0, 4'h2, 1'h1, 1'h0) ^ 64'h0000_1000_0000_0000;
		repeat (8) @(posedge sys_clk);
		rstn <= 1'h1;
		repeat (2) @(posedge sys_clk);
		chk(load_ready, 64'h1);
		chk(phys_width_word, 64'h28);
		foreach (lds[i]) do_load(lds[i].s, lds[i].sel, lds[i].f, lds[i].a);
		// visible selectors, faulted loads left them alone
		for (int i = 0; i < 6; i++) begin
			store_seg <= seg_id_t'(i);
			repeat (2) @(posedge sys_clk);
			chk(store_selector, keep[i]);
		end
		// table edited without reload: cached base must stay in use
		pm.mem[64'h1010] = mk(32'h0A000000, 4'h2, 1'h1, 1'h0);
		foreach (acs[i]) do_acc(acs[i].s, acs[i].o, acs[i].w, acs[i].f, acs[i].l);
		control_register_four <= 32'h20;
		paging_enable <= 1'h1;
		do_acc(SEG_DATA, 64'h4, 1'h0, FLT_NONE, 64'h100004);
		paging_enable <= 1'h0;
		do_acc(SEG_DATA, 64'h8, 1'h0, FLT_NONE, 64'h100008);
		// expand-down segment, fetch rights and a system descriptor
		do_load(SEG_EXTRA2, 16'h0038, FLT_NONE, 64'h1038);
		do_acc(SEG_EXTRA2, 64'h800, 1'h0, FLT_GENERAL, 64'h0);
		do_acc(SEG_EXTRA2, 64'h1000, 1'h0, FLT_NONE, 64'h5000);
		do_acc(SEG_DATA, 64'h4, 1'h0, FLT_GENERAL, 64'h0, 1'h1);
		do_acc(SEG_CODE, 64'h10, 1'h0, FLT_NONE, 64'h10, 1'h1);
		do_load(SEG_DATA, 16'h0040, FLT_GENERAL, 64'h1040);
		// slow descriptor answers, then the long-code sub-mode
		pm.lat = 6;
		wide_address_operation <= 1'h1;
		do_load(SEG_CODE, 16'h0018, FLT_NONE, 64'h1018);
		do_load(SEG_EXTRA3, 16'h0028, FLT_NONE, 64'h1028);
		repeat (2) @(posedge sys_clk);
		chk(code_is_64bit, 64'h1);
		do_acc(SEG_DATA, 64'h12345000, 1'h0, FLT_NONE, 64'h12345000);
		do_acc(SEG_EXTRA3, 64'h10, 1'h0, FLT_NONE, 64'h3010);
		do_acc(SEG_DATA, 64'h0000800000000000, 1'h0, FLT_GENERAL, 64'h0);
		give_verdict();
	end

	// run needs well under 1000 cycles; cut off at 10000
	initial begin
		#200000;
		n_fail++;
		give_verdict();
	end
endmodule

bind segment_address_translation segment_address_translation_sva #(
	.PHYS_ADDR_BITS(PHYS_ADDR_BITS), .LIN_ADDR_BITS(LIN_ADDR_BITS)) chk_i (.sys_clk, .rstn,
	.paging_enable, .global_table_base_reg, .local_table_base_reg, .load_valid, .load_req,
	.load_ready, .load_done, .load_fault, .desc_req_valid, .desc_req_addr, .desc_rsp_valid,
	.acc_valid, .acc_done, .acc_fault, .linear_addr, .phys_valid, .phys_addr,
	.paging_req_valid, .phys_width_word);
